// [design/lsrpt_pkg.sv]
package lsrpt_pkg;

   // Pointer byte layout.
   localparam int PTR_CMD_BIT   = 7;
   localparam int PTR_CLEAR_BIT = 6;
   localparam int PTR_WORD_BIT  = 5;
   localparam int PTR_ADDR_MSB  = 3;
   localparam logic [7:0] PTR_RESET = 8'h00;

   // Register addresses (low four bits of the pointer).
   localparam logic [3:0] ADDR_POWER_CTRL     = 4'h0;
   localparam logic [3:0] ADDR_INTEGRATION    = 4'h1;
   localparam logic [3:0] ADDR_LOWER_LSB      = 4'h2;
   localparam logic [3:0] ADDR_LOWER_MSB      = 4'h3;
   localparam logic [3:0] ADDR_UPPER_LSB      = 4'h4;
   localparam logic [3:0] ADDR_UPPER_MSB      = 4'h5;
   localparam logic [3:0] ADDR_IRQ_CONFIG     = 4'h6;
   localparam logic [3:0] ADDR_RESERVED_A     = 4'h7;
   localparam logic [3:0] ADDR_FACTORY_TEST   = 4'h8;
   localparam logic [3:0] ADDR_RESERVED_B     = 4'h9;
   localparam logic [3:0] ADDR_PART_IDENT     = 4'hA;
   localparam logic [3:0] ADDR_RESERVED_C     = 4'hB;
   localparam logic [3:0] ADDR_CH0_LSB        = 4'hC;
   localparam logic [3:0] ADDR_CH0_MSB        = 4'hD;
   localparam logic [3:0] ADDR_CH1_LSB        = 4'hE;
   localparam logic [3:0] ADDR_CH1_MSB        = 4'hF;

   // Power register.
   localparam logic [1:0] POWER_RESET = 2'h0;
   localparam logic [1:0] POWER_UP    = 2'h3;

   // Integration register fields.
   localparam int GAIN_BIT   = 4;
   localparam int MANUAL_BIT = 3;
   localparam logic [7:0] WINDOW_LENGTH_FIELD_RESET  = 8'h02;
   localparam logic [1:0] WIN_SHORT    = 2'h0;
   localparam logic [1:0] WIN_MEDIUM   = 2'h1;
   localparam logic [1:0] WIN_LONG     = 2'h2;
   localparam logic [1:0] WIN_MANUAL   = 2'h3;

   // Other register reset values.
   localparam logic [7:0]  LIMIT_RESET   = 8'h00;
   localparam logic [5:0]  IRQ_CFG_RESET = 6'h00;
   localparam logic [15:0] COUNT_RESET   = 16'h0000;
   localparam logic [7:0]  READ_ZERO     = 8'h00;
   // Arbitrary identity value.
   localparam logic [7:0]  PART_IDENT_DEFAULT = 8'h5A;

   // Integration timing: windows are whole groups of oscillator cycles.
   localparam longint OSC_HZ     = 735000;
   localparam longint MCLK_HZ    = 25000000;
   localparam longint GROUP_OSC  = 918;
   localparam int unsigned GROUP_CYCLES_NOM = int'((GROUP_OSC * MCLK_HZ) / OSC_HZ);
   localparam logic [8:0] GROUPS_SHORT  = 9'd11;
   localparam logic [8:0] GROUPS_MEDIUM = 9'd81;
   localparam logic [8:0] GROUPS_LONG   = 9'd322;

   // One transfer handed from the link domain to the register domain.
   typedef struct packed {
      logic       is_read;
      logic       first;
      logic [7:0] data;
   } lsrpt_req_t;

   // Threshold and interrupt settings handed to the comparator.
   typedef struct packed {
      logic [15:0] lower_limit;
      logic [15:0] upper_limit;
      logic [5:0]  irq_config;
   } lsrpt_cfg_t;

   typedef enum logic [1:0] {
      ST_OFF,
      ST_PRESET,
      ST_MANUAL_WAIT,
      ST_MANUAL_RUN
   } lsrpt_state_t;

endpackage

// [design/lsrpt_top.sv]
// How it works
// [R1] Host sets bit 7 in pointer bytes.
// [R2] Pointer bit 6 pulses interrupt clear once.
// [R3] Pointer bit 5 selects word transfers.
// [R4] Pointer low nibble selects target register.
// [R5] Pointer resets to zero.
// [R6] First byte of transaction loads pointer.
// [R7] Host writes pointer before register access.
// [R8] Host writes zeros to reserved bits.
// [R9] Power field 03h up, 00h down.
// [R10] Power register reads back written value.
// [R11] Integration register resets to 02h.
// [R12] Gain bit selects 1x or 16x.
// [R13] One setting drives both channels.
// [R14] Field selects 11, 81, 322 groups.
// [R15] Windows scale from one oscillator base.
// [R16] Manual bit starts and stops integration.
// [R17] Manual bit ignored unless field is 11.
// [R18] Host avoids reserved and test addresses.
// [R19] Command byte low nibble stored as pointer.
// [R20] Reads return register named by pointer.
// [R21] Windows counted in 918-cycle oscillator groups.
// [R22] Window end latches counts and restarts.
// [R23] Manual stop also latches counts.
// [R24] Reserved addresses ignore writes, read zero.
module lsrpt_top #(
   parameter int unsigned GROUP_CYCLES = lsrpt_pkg::GROUP_CYCLES_NOM
) (
   input  wire logic                   mclk,
   input  wire logic                   rst_n,
   input  wire logic                   link_clk,
   input  wire logic                   rx_valid,
   input  wire logic                   rx_first,
   input  wire logic [7:0]             rx_byte,
   input  wire logic                   rd_req,
   output logic                        link_busy,
   output logic                        rd_valid,
   output logic [7:0]                  rd_data,
   input  wire logic [15:0]            ch0_accum,
   input  wire logic [15:0]            ch1_accum,
   output logic                        powered,
   output logic                        gain_high,
   output logic                        integrating,
   output logic                        adc_restart,
   output logic                        conv_done,
   output logic                        irq_clear,
   output lsrpt_pkg::lsrpt_cfg_t       cfg
);
   import lsrpt_pkg::*;

   // ---------------- Link domain ----------------
   logic [1:0]  lrst_sync;
   logic        ack_s1;
   logic        ack_s2;
   logic        ack_s3;
   logic        req_tgl;
   logic        ack_tgl;
   lsrpt_req_t  hold;
   logic [7:0]  rd_word;
   logic        lrst_n;

   assign lrst_n = lrst_sync[1];

   always_ff @(posedge link_clk) begin
      lrst_sync <= {lrst_sync[0], rst_n};
   end

   always_ff @(posedge link_clk) begin
      ack_s1 <= ack_tgl;
      ack_s2 <= ack_s1;
      ack_s3 <= ack_s2;
   end

   // Write bytes take priority over a read request in the same cycle.
   always_ff @(posedge link_clk) begin
      if (!lrst_n) begin
         req_tgl   <= 1'b0;
         hold      <= '0;
         link_busy <= 1'b0;
      end else if (!link_busy && (rx_valid || rd_req)) begin
         hold.is_read <= !rx_valid;
         hold.first   <= rx_valid && rx_first;
         hold.data    <= rx_byte;
         req_tgl      <= !req_tgl;
         link_busy    <= 1'b1;
      end else if (ack_s2 != ack_s3) begin
         link_busy <= 1'b0;
      end
   end

   always_ff @(posedge link_clk) begin
      if (!lrst_n) begin
         rd_valid <= 1'b0;
         rd_data  <= READ_ZERO;
      end else begin
         rd_valid <= (ack_s2 != ack_s3) && hold.is_read;
         if ((ack_s2 != ack_s3) && hold.is_read) begin
            rd_data <= rd_word;
         end
      end
   end

   // ---------------- Register domain ----------------
   logic         req_s1;
   logic         req_s2;
   logic         req_s3;
   logic         ev;
   logic [3:0]   ptr_addr;
   logic         ptr_word;
   logic         byte_idx;
   logic [3:0]   tgt;
   logic [1:0]   power_ctrl;
   logic [1:0]   window_length_field;
   logic         manual_bit;
   logic [7:0]   lower_limit_lsb;
   logic [7:0]   lower_limit_msb;
   logic [7:0]   upper_limit_lsb;
   logic [7:0]   upper_limit_msb;
   logic [5:0]   irq_config;
   logic [15:0]  ch0_count;
   logic [15:0]  ch1_count;
   logic         is_cmd;
   logic         is_data_wr;

   always_ff @(posedge mclk) begin
      req_s1  <= req_tgl;
      req_s2  <= req_s1;
      req_s3  <= req_s2;
      ack_tgl <= req_s3;
   end

   assign ev = req_s2 ^ req_s3;
   // [R6] first byte is command
   assign is_cmd     = ev && !hold.is_read && hold.first && hold.data[PTR_CMD_BIT];
   assign is_data_wr = ev && !hold.is_read && !is_cmd;
   // [R3] word pairs bytes
   assign tgt = {ptr_addr[3:1], ptr_addr[0] | (ptr_word & byte_idx)};

   // [R5] pointer resets zero
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ptr_addr <= PTR_RESET[PTR_ADDR_MSB:0];
         ptr_word <= 1'b0;
         byte_idx <= 1'b0;
         irq_clear <= 1'b0;
      end else begin
         // [R2] clear is one pulse
         irq_clear <= is_cmd && hold.data[PTR_CLEAR_BIT];
         if (is_cmd) begin
            // [R19] store select nibble
            ptr_addr <= hold.data[PTR_ADDR_MSB:0];
            ptr_word <= hold.data[PTR_WORD_BIT];
            byte_idx <= 1'b0;
         end else if (ev && ptr_word) begin
            byte_idx <= !byte_idx;
         end
      end
   end

   // [R4] decode target register
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         power_ctrl          <= POWER_RESET;
         // [R11] timing resets 02h
         window_length_field <= WINDOW_LENGTH_FIELD_RESET[1:0];
         manual_bit          <= WINDOW_LENGTH_FIELD_RESET[MANUAL_BIT];
         gain_high           <= WINDOW_LENGTH_FIELD_RESET[GAIN_BIT];
         lower_limit_lsb     <= LIMIT_RESET;
         lower_limit_msb     <= LIMIT_RESET;
         upper_limit_lsb     <= LIMIT_RESET;
         upper_limit_msb     <= LIMIT_RESET;
         irq_config          <= IRQ_CFG_RESET;
      end else if (is_data_wr) begin
         unique case (tgt)
            // [R9] power field write
            ADDR_POWER_CTRL:  power_ctrl <= hold.data[1:0];
            ADDR_INTEGRATION: begin
               window_length_field <= hold.data[1:0];
               manual_bit          <= hold.data[MANUAL_BIT];
               // [R12] gain bit write
               gain_high           <= hold.data[GAIN_BIT];
            end
            ADDR_LOWER_LSB:   lower_limit_lsb <= hold.data;
            ADDR_LOWER_MSB:   lower_limit_msb <= hold.data;
            ADDR_UPPER_LSB:   upper_limit_lsb <= hold.data;
            ADDR_UPPER_MSB:   upper_limit_msb <= hold.data;
            ADDR_IRQ_CONFIG:  irq_config <= hold.data[5:0];
            // [R24] others ignore writes
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cfg <= '0;
      end else begin
         cfg.lower_limit <= {lower_limit_msb, lower_limit_lsb};
         cfg.upper_limit <= {upper_limit_msb, upper_limit_lsb};
         cfg.irq_config  <= irq_config;
      end
   end

   // [R20] read named register
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rd_word <= READ_ZERO;
      end else if (ev && hold.is_read) begin
         unique case (tgt)
            // [R10] power reads back
            ADDR_POWER_CTRL:  rd_word <= {6'h00, power_ctrl};
            ADDR_INTEGRATION: rd_word <= {3'h0, gain_high, manual_bit, 1'b0, window_length_field};
            ADDR_LOWER_LSB:   rd_word <= lower_limit_lsb;
            ADDR_LOWER_MSB:   rd_word <= lower_limit_msb;
            ADDR_UPPER_LSB:   rd_word <= upper_limit_lsb;
            ADDR_UPPER_MSB:   rd_word <= upper_limit_msb;
            ADDR_IRQ_CONFIG:  rd_word <= {2'h0, irq_config};
            ADDR_PART_IDENT:  rd_word <= PART_IDENT_DEFAULT;
            ADDR_CH0_LSB:     rd_word <= ch0_count[7:0];
            ADDR_CH0_MSB:     rd_word <= ch0_count[15:8];
            ADDR_CH1_LSB:     rd_word <= ch1_count[7:0];
            ADDR_CH1_MSB:     rd_word <= ch1_count[15:8];
            // [R24] reserved reads zero
            default:          rd_word <= READ_ZERO;
         endcase
      end
   end

   // ---------------- Integration timing ----------------
   lsrpt_state_t state;
   logic [15:0]  cyc_cnt;
   logic [8:0]   grp_cnt;
   logic [8:0]   win_groups;
   logic         group_end;
   logic         latch;

   // [R14] field to group count
   always_comb begin
      unique case (window_length_field)
         WIN_SHORT:  win_groups = GROUPS_SHORT;
         WIN_MEDIUM: win_groups = GROUPS_MEDIUM;
         WIN_LONG:   win_groups = GROUPS_LONG;
         WIN_MANUAL: win_groups = GROUPS_LONG;
      endcase
   end

   // [R15] one shared base
   // [R21] group of oscillator cycles
   assign group_end = (cyc_cnt == 16'(GROUP_CYCLES - 1));

   // [R13] one timer for both channels
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state       <= ST_OFF;
         cyc_cnt     <= '0;
         grp_cnt     <= '0;
         integrating <= 1'b0;
         adc_restart <= 1'b0;
         latch       <= 1'b0;
      end else begin
         adc_restart <= 1'b0;
         latch       <= 1'b0;
         unique case (state)
            ST_OFF: begin
               integrating <= 1'b0;
               if (power_ctrl == POWER_UP) begin
                  state       <= (window_length_field == WIN_MANUAL) ? ST_MANUAL_WAIT : ST_PRESET;
                  cyc_cnt     <= '0;
                  grp_cnt     <= '0;
                  adc_restart <= 1'b1;
                  integrating <= window_length_field != WIN_MANUAL;
               end
            end
            ST_PRESET: begin
               cyc_cnt <= group_end ? '0 : cyc_cnt + 16'h0001;
               if (power_ctrl != POWER_UP) begin
                  state <= ST_OFF;
                  integrating <= 1'b0;
               end else if (window_length_field == WIN_MANUAL) begin
                  state       <= ST_MANUAL_WAIT;
                  integrating <= 1'b0;
               end else if (group_end) begin
                  // [R22] latch and restart
                  if (grp_cnt + 9'h001 >= win_groups) begin
                     grp_cnt     <= '0;
                     latch       <= 1'b1;
                     adc_restart <= 1'b1;
                  end else begin
                     grp_cnt <= grp_cnt + 9'h001;
                  end
               end
            end
            ST_MANUAL_WAIT: begin
               if (power_ctrl != POWER_UP) begin
                  state <= ST_OFF;
               end else if (window_length_field != WIN_MANUAL) begin
                  state       <= ST_PRESET;
                  cyc_cnt     <= '0;
                  grp_cnt     <= '0;
                  adc_restart <= 1'b1;
                  integrating <= 1'b1;
               // [R16] manual start
               end else if (manual_bit) begin
                  state       <= ST_MANUAL_RUN;
                  adc_restart <= 1'b1;
                  integrating <= 1'b1;
               end
            end
            ST_MANUAL_RUN: begin
               // [R17] only while field is 11
               if (power_ctrl != POWER_UP || window_length_field != WIN_MANUAL || !manual_bit) begin
                  // [R23] manual stop latches
                  latch       <= 1'b1;
                  integrating <= 1'b0;
                  state       <= (power_ctrl != POWER_UP) ? ST_OFF : ST_MANUAL_WAIT;
               end
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ch0_count <= COUNT_RESET;
         ch1_count <= COUNT_RESET;
         conv_done <= 1'b0;
         powered   <= 1'b0;
      end else begin
         conv_done <= latch;
         powered   <= power_ctrl == POWER_UP;
         if (latch) begin
            ch0_count <= ch0_accum;
            ch1_count <= ch1_accum;
         end
      end
   end

endmodule

// [verif/lsrpt_chk.sv]
module lsrpt_chk #(
   parameter int unsigned GROUP_CYCLES = lsrpt_pkg::GROUP_CYCLES_NOM
) (
   input wire logic       mclk,
   input wire logic       rst_n,
   input wire logic       link_clk,
   input wire logic       rx_valid,
   input wire logic       rd_req,
   input wire logic       link_busy,
   input wire logic       rd_valid,
   input wire logic [7:0] rd_data,
   input wire logic       powered,
   input wire logic       integrating,
   input wire logic       adc_restart,
   input wire logic       conv_done,
   input wire logic       irq_clear
);
   sequence take_rd;
      rd_req && !rx_valid && !link_busy;
   endsequence
   sequence answer;
      ##[1:20] rd_valid;
   endsequence

   rd_answer_a: assert property (@(posedge link_clk) disable iff (!rst_n)
      take_rd |-> answer) else $error("read not answered in time");
   busy_set_a: assert property (@(posedge link_clk) disable iff (!rst_n)
      (rx_valid || rd_req) && !link_busy |=> link_busy) else $error("request not taken");
   busy_drop_a: assert property (@(posedge link_clk) disable iff (!rst_n)
      $rose(rd_valid) |-> $fell(link_busy)) else $error("busy not dropped with answer");
   rd_pulse_a: assert property (@(posedge link_clk) disable iff (!rst_n)
      rd_valid |=> !rd_valid) else $error("read strobe too long");
   rd_hold_a: assert property (@(posedge link_clk) disable iff (!rst_n)
      !rd_valid |-> $stable(rd_data)) else $error("read data moved without strobe");
   clr_once_a: assert property (@(posedge mclk) disable iff (!rst_n)
      irq_clear |=> !irq_clear) else $error("clear pulse stuck");
   done_once_a: assert property (@(posedge mclk) disable iff (!rst_n)
      conv_done |=> !conv_done) else $error("done pulse stuck");
   restart_once_a: assert property (@(posedge mclk) disable iff (!rst_n)
      adc_restart |=> !adc_restart) else $error("restart pulse stuck");
   pwr_int_a: assert property (@(posedge mclk) disable iff (!rst_n)
      integrating && !powered |=> !integrating) else $error("integrating while off");
endmodule

bind lsrpt_top lsrpt_chk #(.GROUP_CYCLES(GROUP_CYCLES)) chk (.mclk, .rst_n, .link_clk, .rx_valid, .rd_req,
   .link_busy, .rd_valid, .rd_data, .powered, .integrating, .adc_restart, .conv_done, .irq_clear);

// [verif/lsrpt_host.sv]
module lsrpt_host (
   input  wire logic  link_clk,
   input  wire logic  link_busy,
   output logic       rx_valid,
   output logic       rx_first,
   output logic [7:0] rx_byte,
   output logic       rd_req
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      rx_valid = 1'h0;
      rx_first = 1'h0;
      rx_byte = 8'h00;
      rd_req = 1'h0;
   end
   // A released data line shows the inverse so stale bytes are not mistaken for data.
   task automatic xfer(input logic rd, input logic first, input logic [7:0] b);
      int n;
      n = 0;
      @(negedge link_clk);
      rx_valid = !rd;
      rd_req = rd;
      rx_first = first;
      rx_byte = b;
      @(negedge link_clk);
      rx_valid = 1'h0;
      rd_req = 1'h0;
      rx_first = 1'h0;
      rx_byte = ~b;
      while (link_busy !== 1'h0 && n < 40) begin
         @(negedge link_clk);
         n++;
      end
   endtask
   task automatic cmd(input logic [7:0] p);
      xfer(1'h0, 1'h1, {1'h1, p[6:5], 1'h0, p[3:0]});
   endtask
endmodule

// [verif/lsrpt_top_tb.sv]
module lsrpt_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import lsrpt_pkg::*;
   localparam int unsigned GC = 4;
   logic        mclk = 1'h0;
   logic        link_clk = 1'h0;
   logic        rst_n = 1'h0;
   logic [15:0] ch0_accum = 16'h0000;
   logic [15:0] ch1_accum = 16'h0000;
   logic        rx_valid, rx_first, rd_req, link_busy, rd_valid;
   logic [7:0]  rx_byte, rd_data;
   logic        powered, gain_high, integrating, adc_restart, conv_done, irq_clear;
   lsrpt_cfg_t  cfg;
   int          fail_count = 0;
   int          n_checks = 0;
   int          n_clr = 0;
   int          grp [3] = '{11, 81, 322};
   logic [3:0]  rsv [4] = '{4'h7, 4'h8, 4'h9, 4'hB};
   logic [31:0] seed = 32'h406AF3F0;
   logic [31:0] r;
   logic [7:0]  expq [$];

   always #20 mclk = ~mclk;
   always #6 link_clk = ~link_clk;

   lsrpt_top #(.GROUP_CYCLES(GC)) DUT (.mclk, .rst_n, .link_clk, .rx_valid, .rx_first, .rx_byte, .rd_req,
      .link_busy, .rd_valid, .rd_data, .ch0_accum, .ch1_accum, .powered, .gain_high, .integrating,
      .adc_restart, .conv_done, .irq_clear, .cfg);
   lsrpt_host host (.link_clk, .link_busy, .rx_valid, .rx_first, .rx_byte, .rd_req);

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic mism(input string m);
      fail_count++;
      $display("mismatch at %0t: %s", $time, m);
   endtask
   task automatic check_rd(input logic [7:0] g, input logic [7:0] e);
      n_checks++;
      if (g !== e) mism($sformatf("read %h expected %h", g, e));
   endtask
   task automatic check_val(input logic [15:0] g, input logic [15:0] e);
      n_checks++;
      if (g !== e) mism($sformatf("output %h expected %h", g, e));
   endtask
   task automatic conclude();
      if (expq.size() != 0) mism("reads never answered");
      $display("checks %0d, mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   always @(posedge link_clk) begin
      if (rd_valid === 1'h1) begin
         if (expq.size() == 0) mism("read without request");
         else check_rd(rd_data, expq.pop_front());
      end
   end
   always @(posedge mclk) begin
      if (irq_clear === 1'h1) n_clr++;
   end

   task automatic rd(input logic [7:0] e);
      expq.push_back(e);
      host.xfer(1'h1, 1'h0, 8'h00);
   endtask
   // pointer goes first and names any register address, reserved ones included
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      host.cmd({4'h8, a});
      host.xfer(1'h0, 1'h0, d);
   endtask
   task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
      host.cmd({4'h8, a});
      rd(e);
   endtask
   task automatic wr_word(input logic [3:0] a, input logic [15:0] d);
      host.cmd({4'hA, a});
      host.xfer(1'h0, 1'h0, d[7:0]);
      host.xfer(1'h0, 1'h0, d[15:8]);
   endtask
   task automatic rd_word(input logic [3:0] a, input logic [15:0] e);
      host.cmd({4'hA, a});
      rd(e[7:0]);
      rd(e[15:8]);
   endtask
   task automatic settle();
      repeat (4) @(negedge mclk);
   endtask
   task automatic set_accum();
      r = rnd();
      @(negedge mclk);
      ch0_accum = r[15:0];
      ch1_accum = r[31:16];
   endtask
   // Measures the spacing of two completion pulses in register clocks.
   task automatic conv_gap(output int n);
      n = 0;
      while (conv_done !== 1'h1 && n < 3000) begin
         @(negedge mclk);
         n++;
      end
      n = 0;
      do begin
         @(negedge mclk);
         n++;
      end while (conv_done !== 1'h1 && n < 3000);
   endtask

   initial begin
      logic [7:0] d;
      int n;
      repeat (6) @(negedge mclk);
      rst_n = 1'h1;
      repeat (5) @(negedge link_clk);
      rd(8'h00);
      rd_reg(ADDR_INTEGRATION, 8'h02);
      $display("reset test done");
      for (int i = 0; i < 4; i++) begin
         r = rnd();
         d = (i == 2) ? 8'h00 : (i == 3) ? 8'h03 : {6'h00, r[1:0]};
         wr_reg(ADDR_POWER_CTRL, d);
         rd_reg(ADDR_POWER_CTRL, d);
         settle();
         check_val({15'h0, powered}, {15'h0, d == 8'h03});
      end
      foreach (rsv[i]) begin
         r = rnd();
         wr_reg(rsv[i], r[7:0]);
         rd_reg(rsv[i], 8'h00);
      end
      r = rnd();
      wr_word(ADDR_LOWER_LSB, r[15:0]);
      wr_word(ADDR_UPPER_LSB, r[31:16]);
      settle();
      check_val(cfg.lower_limit, r[15:0]);
      check_val(cfg.upper_limit, r[31:16]);
      rd_word(ADDR_LOWER_LSB, r[15:0]);
      r = rnd();
      wr_reg(ADDR_IRQ_CONFIG, {2'h0, r[5:0]});
      rd_reg(ADDR_IRQ_CONFIG, {2'h0, r[5:0]});
      settle();
      check_val({10'h000, cfg.irq_config}, {10'h000, r[5:0]});
      rd_reg(ADDR_PART_IDENT, PART_IDENT_DEFAULT);
      n = n_clr;
      host.cmd(8'hC1);
      rd(8'h02);
      host.cmd(8'h81);
      settle();
      check_val(16'(n_clr - n), 16'h0001);
      $display("register tests done");
      for (int f = 0; f < 3; f++) begin
         set_accum();
         d = {3'h0, r[0], r[1], 1'h0, 2'(f)};
         wr_reg(ADDR_INTEGRATION, d);
         settle();
         check_val({15'h0, gain_high}, {15'h0, d[4]});
         conv_gap(n);
         check_val(16'(n), 16'(grp[f] * GC));
         rd_word(ADDR_CH0_LSB, r[15:0]);
         rd_word(ADDR_CH1_LSB, r[31:16]);
      end
      $display("timing test done");
      wr_reg(ADDR_INTEGRATION, 8'h0B);
      settle();
      check_val({15'h0, integrating}, 16'h0001);
      set_accum();
      wr_reg(ADDR_INTEGRATION, 8'h03);
      settle();
      check_val({15'h0, integrating}, 16'h0000);
      rd_word(ADDR_CH0_LSB, r[15:0]);
      rd_word(ADDR_CH1_LSB, r[31:16]);
      settle();
      $display("manual test done");
      conclude();
   end

   // The whole run needs about 150 us; the limit leaves ample margin.
   initial begin
      #400000;
      mism("watchdog expired");
      conclude();
   end
endmodule
